// >>> design/umc_top.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module umc_top (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rx_in,
    input  wire logic        rx_err,
    output logic             tx_out,
    output logic             line_driver_enable,
    output logic             irq_req
);
    import umc_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  ctrl0_q;
    logic [7:0]  ctrl1_q;
    logic [7:0]  cmp_addr_q;
    logic [15:0] div_q;
    logic [8:0]  tx_shift_q;
    logic [3:0]  tx_bits_q;
    logic        tx_busy_q;
    logic [3:0]  tx_ovs_q;
    logic [7:0]  rx_data_q;
    logic        rx_is_addr_q;
    logic        rx_avail_q;
    logic        addr_match_q;
    logic        rx_busy_q;
    logic [3:0]  rx_ovs_q;
    logic [3:0]  rx_bits_q;
    logic [8:0]  rx_shift_q;
    logic        rx_prev_q;
    logic        wr_q;
    logic [11:0] idx_q;
    logic        rd_q;
    logic [15:0] count;
    logic        tick;
    logic        nine_on;
    logic        rx_on;
    logic        rx_line;
    logic        tx_raw;
    logic        byte_done;
    logic        byte_addr;
    logic        byte_irq;
    logic        timer_irq;
    umc_filt_t   filt;
    logic [7:0]  rd_val;
    logic [15:0] brg_view;

    umc_baud u_baud (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .divisor (div_q),
        .count   (count),
        .tick    (tick)
    );

    assign nine_on = ctrl1_q[UMC_B_NINE];
    assign rx_on   = ctrl0_q[UMC_B_REN];
    assign filt    = umc_filt_t'({ctrl1_q[UMC_B_MODE_HI], ctrl1_q[UMC_B_MODE_LO]});

    // ****************************************
    // Bus slave, zero wait states
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            idx_q <= 12'h000;
        end else if (hready) begin
            wr_q  <= hsel && htrans[1] && hwrite;
            rd_q  <= hsel && htrans[1] && !hwrite;
            idx_q <= haddr[13:2];
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl0_q    <= UMC_CTRL0_RST;
            ctrl1_q    <= UMC_CTRL1_RST;
            cmp_addr_q <= UMC_ADDR_RST;
            div_q      <= UMC_BRG_RST;
        end else if (wr_q) begin
            unique case (idx_q)
                UMC_IDX_CTRL0: ctrl0_q    <= hwdata[7:0];
                UMC_IDX_CTRL1: ctrl1_q    <= hwdata[7:0];
                UMC_IDX_ADDR:  cmp_addr_q <= hwdata[7:0];
                UMC_IDX_BRH:   div_q[15:8] <= hwdata[7:0];
                UMC_IDX_BRL:   div_q[7:0]  <= hwdata[7:0];
                default:       ;
            endcase
        end
    end

    // Readback view: reload value or the live counter.
    assign brg_view = ctrl1_q[UMC_B_BGC] ? count : div_q;

    always_comb begin
        rd_val = 8'h00;
        unique case (haddr[13:2])
            UMC_IDX_CTRL0: rd_val = ctrl0_q;
            UMC_IDX_CTRL1: rd_val = ctrl1_q;
            UMC_IDX_ADDR:  rd_val = cmp_addr_q;
            UMC_IDX_BRH:   rd_val = brg_view[15:8];
            UMC_IDX_BRL:   rd_val = brg_view[7:0];
            UMC_IDX_STAT:  rd_val = {5'h00, tx_busy_q, rx_is_addr_q, rx_avail_q};
            UMC_IDX_TXD:   rd_val = rx_data_q;
            default:       rd_val = 8'h00;
        endcase
    end

    // Read data is captured at the address phase so it stands in the data phase.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                hrdata <= {24'h00_0000, rd_val};
            end
        end
    end

    // ****************************************
    // Transmitter, sixteen ticks a bit
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_busy_q  <= 1'b0;
            tx_shift_q <= 9'h1FF;
            tx_bits_q  <= 4'h0;
            tx_ovs_q   <= 4'h0;
            tx_raw     <= 1'b1;
        end else if (!tx_busy_q) begin
            tx_raw <= 1'b1;
            if (wr_q && idx_q == UMC_IDX_TXD && ctrl0_q[UMC_B_TEN]) begin
                tx_busy_q  <= 1'b1;
                tx_shift_q <= {ctrl1_q[UMC_B_TXBIT], hwdata[7:0]};
                tx_bits_q  <= nine_on ? 4'hA : 4'h9;
                tx_ovs_q   <= 4'h0;
                tx_raw     <= 1'b0;
            end
        end else if (tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == UMC_OVS_LAST) begin
                if (tx_bits_q == 4'h0) begin
                    tx_busy_q <= 1'b0;
                    tx_raw    <= 1'b1;
                end else if (tx_bits_q == 4'h1) begin
                    tx_bits_q <= 4'h0;
                    tx_raw    <= 1'b1;
                end else begin
                    tx_bits_q  <= tx_bits_q - 4'h1;
                    tx_raw     <= tx_shift_q[0];
                    tx_shift_q <= {1'b1, tx_shift_q[8:1]};
                end
            end
        end
    end

    // Infrared pulse is a short low slot in the middle of each zero bit.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_out             <= 1'b1;
            line_driver_enable <= 1'b0;
        end else begin
            if (ctrl1_q[UMC_B_IR]) begin
                tx_out <= tx_raw || !(tx_ovs_q >= UMC_IR_LO && tx_ovs_q <= UMC_IR_HI);
            end else begin
                tx_out <= tx_raw;
            end
            line_driver_enable <= tx_busy_q ^ ctrl1_q[UMC_B_DRIVER_EN_POLARITY];
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    assign rx_line = ctrl1_q[UMC_B_IR] ? !rx_in : rx_in;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_busy_q  <= 1'b0;
            rx_ovs_q   <= 4'h0;
            rx_bits_q  <= 4'h0;
            rx_shift_q <= 9'h000;
            rx_prev_q  <= 1'b1;
            byte_done  <= 1'b0;
        end else begin
            byte_done <= 1'b0;
            rx_prev_q <= rx_line;
            if (!rx_on) begin
                rx_busy_q <= 1'b0;
            end else if (!rx_busy_q) begin
                if (rx_prev_q && !rx_line) begin
                    rx_busy_q <= 1'b1;
                    rx_ovs_q  <= 4'h0;
                    // The start bit is shifted in first and falls out of the register.
                    rx_bits_q <= nine_on ? 4'hA : 4'h9;
                end
            end else if (tick) begin
                rx_ovs_q <= rx_ovs_q + 4'h1;
                if (rx_ovs_q == UMC_OVS_MID) begin
                    if (rx_bits_q == 4'h0) begin
                        rx_busy_q <= 1'b0;
                        byte_done <= 1'b1;
                    end else begin
                        rx_bits_q  <= rx_bits_q - 4'h1;
                        rx_shift_q <= nine_on ? {rx_line, rx_shift_q[8:1]}
                                              : {1'b0, rx_line, rx_shift_q[7:1]};
                    end
                end
            end
        end
    end

    assign byte_addr = nine_on && rx_shift_q[8];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_q    <= 8'h00;
            rx_is_addr_q <= 1'b0;
            rx_avail_q   <= 1'b0;
            addr_match_q <= 1'b0;
        end else begin
            if (byte_done) begin
                rx_data_q    <= rx_shift_q[7:0];
                rx_is_addr_q <= byte_addr;
                if (byte_addr) begin
                    addr_match_q <= rx_shift_q[7:0] == cmp_addr_q;
                end
            end
            // A byte arriving in the clearing cycle keeps its flag.
            if (byte_done) begin
                rx_avail_q <= 1'b1;
            end else if (rd_q && idx_q == UMC_IDX_TXD) begin
                rx_avail_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Interrupt request filter
    // ****************************************
    always_comb begin
        byte_irq = 1'b1;
        if (nine_on) begin
            unique case (filt)
                UMC_FILT_ALL:   byte_irq = 1'b1;
                UMC_FILT_ADDR:  byte_irq = byte_addr;
                UMC_FILT_MATCH: byte_irq = byte_addr ? rx_shift_q[7:0] == cmp_addr_q
                                                     : addr_match_q;
                UMC_FILT_DATA:  byte_irq = !byte_addr && addr_match_q;
            endcase
        end
    end

    assign timer_irq = !rx_on && ctrl1_q[UMC_B_BGC] && tick;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= (byte_done && byte_irq && !ctrl1_q[UMC_B_RDMASK])
                    || (rx_on && rx_err)
                    || timer_irq;
        end
    end
endmodule

// >>> design/umc_pkg.sv
// Operation
// - Framing bit selects nine-bit multiprocessor mode.
// - Filter mode bits 7,5 act only then.
// - Mode 00 interrupts on every byte.
// - Mode 01 interrupts on address bytes only.
// - Mode 10 matched address plus following data.
// - Mode 11 data after matched address only.
// - Ninth bit transmits control value in mode.
// - Driver enable polarity chosen by bit 3.
// - Receiver off and control set: timer interrupts.
// - Control clear: baud bytes read reload divisor.
// - Control set: baud bytes read live count.
// - Receiver on: control only selects readback.
// - Mask clear: data and errors interrupt.
// - Mask set: only errors and timer interrupt.
// - Infrared bit routes data through codec.
// - Address bytes compare to 8-bit address.
// - Two baud bytes form 16-bit divisor.
// - Receiver enable bit turns receiver on.
package umc_pkg;
    // ****************************************
    // Register map, word index times four
    // ****************************************
    localparam logic [11:0] UMC_IDX_CTRL0  = 12'hF42;
    localparam logic [11:0] UMC_IDX_CTRL1  = 12'hF43;
    localparam logic [11:0] UMC_IDX_ADDR   = 12'hF45;
    localparam logic [11:0] UMC_IDX_BRH    = 12'hF46;
    localparam logic [11:0] UMC_IDX_BRL    = 12'hF47;
    localparam logic [11:0] UMC_IDX_STAT   = 12'hF48;
    localparam logic [11:0] UMC_IDX_TXD    = 12'hF49;
    localparam logic [7:0]  UMC_CTRL1_RST  = 8'h00;
    localparam logic [7:0]  UMC_CTRL0_RST  = 8'h00;
    localparam logic [7:0]  UMC_ADDR_RST   = 8'h00;
    localparam logic [15:0] UMC_BRG_RST    = 16'hFFFF;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int UMC_B_MODE_HI = 7;
    localparam int UMC_B_NINE    = 6;
    localparam int UMC_B_MODE_LO = 5;
    localparam int UMC_B_TXBIT   = 4;
    localparam int UMC_B_DRIVER_EN_POLARITY   = 3;
    localparam int UMC_B_BGC     = 2;
    localparam int UMC_B_RDMASK  = 1;
    localparam int UMC_B_IR      = 0;
    localparam int UMC_B_TEN     = 7;
    localparam int UMC_B_REN     = 6;
    localparam logic [3:0] UMC_OVS_LAST = 4'hF;
    localparam logic [3:0] UMC_OVS_MID  = 4'h7;
    localparam logic [3:0] UMC_IR_LO    = 4'h6;
    localparam logic [3:0] UMC_IR_HI    = 4'h9;
    typedef enum logic [1:0] {
        UMC_FILT_ALL   = 2'b00,
        UMC_FILT_ADDR  = 2'b01,
        UMC_FILT_MATCH = 2'b10,
        UMC_FILT_DATA  = 2'b11
    } umc_filt_t;
endpackage

// >>> design/umc_baud.sv
`timescale 1ns/1ps
module umc_baud (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [15:0] divisor,
    output logic [15:0]      count,
    output logic             tick
);
    import umc_pkg::*;
    // ****************************************
    // Down counter with reload
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count <= UMC_BRG_RST;
            tick  <= 1'b0;
        end else if (count <= 16'h0001) begin
            count <= divisor;
            tick  <= 1'b1;
        end else begin
            count <= count - 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule

// >>> tb/umc_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checks
// ****************************************
module umc_monitor (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rx_err,
    input wire logic        tx_out,
    input wire logic        line_driver_enable,
    input wire logic        irq_req
);
    // Byte shadows indexed by address bits 4:2, so checks need no decoder of their own.
    logic [7:0] sh_q [8];
    logic       wr_q;
    logic [2:0] wa_q;
    logic       sel;
    logic       tmr;
    assign sel = hsel && htrans[1] && haddr[13:5] == 9'h1E8;
    assign tmr = sh_q[3][2] && !sh_q[2][6];
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sh_q <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
            wr_q <= 1'b0;
            wa_q <= 3'h0;
        end else begin
            if (wr_q) begin
                sh_q[wa_q] <= hwdata[7:0];
            end
            wr_q <= sel && hwrite;
            wa_q <= haddr[4:2];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    chk_ready_high: assert property (hreadyout) else $error("ready dropped");
    chk_resp_okay: assert property (!hresp) else $error("error response");
    chk_unmapped_zero: assert property (hsel && htrans[1] && !hwrite && haddr[13:8] != 6'h3D
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    chk_reg_readback: assert property (sel && !hwrite && (haddr[4:2] inside {3'd2, 3'd3, 3'd5}
        || haddr[4:3] == 2'b11 && !sh_q[3][2])
        |=> hrdata == {24'h0, sh_q[$past(haddr[4:2])]}) else $error("readback wrong");
    chk_de_polarity: assert property (!tx_out && $past(!tx_out) && $stable(sh_q[3][3])
        |-> line_driver_enable == !sh_q[3][3]) else $error("driver enable level");
    chk_timer_period: assert property (irq_req && tmr && {sh_q[6], sh_q[7]} == 16'h0002
        ##1 tmr [*2] |-> irq_req) else $error("timer period");
    chk_quiet_masked: assert property (sh_q[3][1] && !tmr && $past(sh_q[3][1] && !tmr)
        && !rx_err && !$past(rx_err) && !$past(rx_err, 2) |-> !irq_req)
        else $error("masked data interrupted");
    chk_reset_idle: assert property ($rose(arst_n) |-> tx_out && !irq_req && !line_driver_enable)
        else $error("not idle after reset");
    chk_irq_pulse: assert property (irq_req && !tmr |=> !irq_req) else $error("irq too long");
endmodule
bind umc_top umc_monitor i_mon (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_err(rx_err), .tx_out(tx_out), .line_driver_enable(line_driver_enable),
    .irq_req(irq_req));

// >>> tb/umc_node.sv
`timescale 1ns/1ps
// ****************************************
// Remote serial node
// ****************************************
module umc_node #(
    parameter int BIT_CYC = 32
) (
    input  wire logic clk_sys,
    output logic      rx_in,
    input  wire logic tx_out
);
    initial rx_in = 1'b1;
    // The mark level is also the idle level, so a released line reads high.
    task automatic send(input logic [8:0] c, input logic nine);
        logic [11:0] fr;
        fr = nine ? {2'b11, c[8], c[7:0], 1'b0} : {3'b111, c[7:0], 1'b0};
        @(posedge clk_sys);
        for (int i = 0; i < 12; i++) begin
            rx_in <= fr[i];
            repeat (BIT_CYC) @(posedge clk_sys);
        end
    endtask
    task automatic listen(output logic [8:0] c);
        while (tx_out !== 1'b0) @(posedge clk_sys);
        repeat (BIT_CYC / 2) @(posedge clk_sys);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys);
            c[i] = tx_out;
        end
    endtask
endmodule

// >>> tb/uart_multiproc_control_test.sv
`timescale 1ns/1ps
// ****************************************
// Register and line tests
// ****************************************
module uart_multiproc_control_test;
    import umc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'b00;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic        rx_err  = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        rx_in;
    logic        tx_out;
    logic        line_driver_enable;
    logic        irq_req;
    logic [31:0] rd;
    logic [8:0]  ch;
    logic [3:0]  pat [4] = '{4'b1111, 4'b0101, 4'b0011, 4'b0010};
    logic [8:0]  seq [4] = '{9'h15A, 9'h033, 9'h1C3, 9'h044};
    int          miscompares = 0;
    int          checked = 0;
    int          irqs = 0;
    int          n;
    umc_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in), .rx_err(rx_err),
        .tx_out(tx_out), .line_driver_enable(line_driver_enable), .irq_req(irq_req));
    umc_node i_node (.clk_sys(clk_sys), .rx_in(rx_in), .tx_out(tx_out));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (irq_req === 1'b1) begin
            irqs <= irqs + 1;
        end
    end
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {18'h0, idx, 2'b00};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        check(rd, {24'h0, exp});
    endtask
    task automatic frame(input logic [8:0] c, input logic nine, input int exp);
        int base;
        base = irqs;
        i_node.send(c, nine);
        check(32'(irqs - base), 32'(exp));
    endtask
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        rdc(UMC_IDX_CTRL1, 8'h00);
        rdc(UMC_IDX_BRH, 8'hFF);
        rdc(UMC_IDX_BRL, 8'hFF);
        xfer(1'b1, 12'h100, 8'h5A);
        rdc(12'h100, 8'h00);
        xfer(1'b1, UMC_IDX_CTRL1, 8'hA5);
        rdc(UMC_IDX_CTRL1, 8'hA5);
        $display("test registers done");
        xfer(1'b1, UMC_IDX_BRH, 8'h00);
        xfer(1'b1, UMC_IDX_BRL, 8'h02);
        xfer(1'b1, UMC_IDX_CTRL1, 8'h04);
        xfer(1'b0, UMC_IDX_BRH, 8'h00);
        check(32'(rd[7:0] != 8'h00), 32'h1);
        for (n = 0; n < 70000 && irq_req !== 1'b1; n++) @(posedge clk_sys);
        @(posedge clk_sys);
        for (n = 1; n < 10 && irq_req !== 1'b1; n++) @(posedge clk_sys);
        check(32'(n), 32'h2);
        // Two reads three cycles apart catch both phases of a period-two count.
        xfer(1'b0, UMC_IDX_BRL, 8'h00);
        n = int'(rd[7:0]);
        xfer(1'b0, UMC_IDX_BRL, 8'h00);
        check(32'(n + int'(rd[7:0])), 32'h3);
        xfer(1'b1, UMC_IDX_CTRL1, 8'h00);
        rdc(UMC_IDX_BRH, 8'h00);
        rdc(UMC_IDX_BRL, 8'h02);
        xfer(1'b1, UMC_IDX_CTRL0, 8'h40);
        xfer(1'b1, UMC_IDX_CTRL1, 8'h04);
        n = irqs;
        repeat (40) @(posedge clk_sys);
        check(32'(irqs - n), 32'h0);
        xfer(1'b0, UMC_IDX_BRL, 8'h00);
        n = int'(rd[7:0]);
        xfer(1'b0, UMC_IDX_BRL, 8'h00);
        check(32'(n + int'(rd[7:0])), 32'h3);
        $display("test timer done");
        xfer(1'b1, UMC_IDX_ADDR, 8'h5A);
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, UMC_IDX_CTRL1, {m[1], 1'b1, m[0], 5'h00});
            for (int k = 0; k < 4; k++) begin
                frame(seq[k], 1'b1, int'(pat[m][k]));
            end
        end
        rdc(UMC_IDX_STAT, 8'h01);
        rdc(UMC_IDX_TXD, 8'h44);
        rdc(UMC_IDX_STAT, 8'h00);
        $display("test filter modes done");
        xfer(1'b1, UMC_IDX_CTRL1, 8'h20);
        frame(9'h033, 1'b0, 1);
        xfer(1'b1, UMC_IDX_CTRL1, 8'h02);
        frame(9'h033, 1'b0, 0);
        n = irqs;
        rx_err <= 1'b1;
        @(posedge clk_sys);
        rx_err <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check(32'(irqs - n), 32'h1);
        $display("test masking done");
        xfer(1'b1, UMC_IDX_CTRL0, 8'hC0);
        xfer(1'b1, UMC_IDX_CTRL1, 8'h58);
        xfer(1'b1, UMC_IDX_TXD, 8'hA5);
        fork
            i_node.listen(ch);
            begin
                repeat (100) @(posedge clk_sys);
                check({31'h0, line_driver_enable}, 32'h0);
            end
        join
        check({23'h0, ch}, 32'h1A5);
        repeat (64) @(posedge clk_sys);
        check({31'h0, line_driver_enable}, 32'h1);
        xfer(1'b1, UMC_IDX_CTRL1, 8'h01);
        xfer(1'b1, UMC_IDX_TXD, 8'h00);
        for (n = 0; n < 200 && tx_out !== 1'b0; n++) @(posedge clk_sys);
        for (n = 0; n < 40 && tx_out !== 1'b1; n++) @(posedge clk_sys);
        check(32'(n), 32'h8);
        $display("test transmit done");
        summarize();
    end
endmodule
